/* File: logic/cmr_regs.sv */
// core miscellaneous control registers: feature word, linked-load frame,
// extended page context and diagnostic control
// assumes single-cycle read/write strobes from the coprocessor move unit
// and event strobes from the pipeline, all on the core clock
// Function
// - feature word read-only, reset value 0xA0
// - reserved bits read zero, software writes zero
// - feature flag one means option present
// - linked-load frame in bits 47:12, rest zero
// - exception return clears linked-load register unless a load-linked lands in the same cycle
// - TLB exception captures address bits 47:13
// - TLB exception captures region bits 63:62
// - page table base software-owned, hardware never changes
// - context value addresses paired 8-byte entries
// - diagnostic relax bits lift pipeline restrictions
// - writing one flushes instruction TLB
// - writing one flushes branch target buffer
// - return-stack disable holds while bit set
module cmr_regs
    import cmr_pkg::*;
#(
    parameter logic [31:0] CFG_VALUE = cmr_pkg::CMR_CFG_RESET // feature word
) (
    input wire logic i_ref_clk,                  // core clock, 25 MHz
    input wire logic i_resetn,                   // synchronous reset, low
    input wire logic i_cop_rd,                   // register read strobe
    input wire logic i_cop_wr,                   // register write strobe
    input wire logic [4:0] i_cop_regnum,         // register number
    input wire logic [2:0] i_cop_sel,            // select number
    input wire logic [63:0] i_cop_wdata,         // write data
    output logic [63:0] o_cop_rdata,             // read data, one cycle later
    output logic o_cop_rvalid,                   // read data valid pulse
    output logic o_cop_rhit,                     // read hit a mapped register
    input wire logic i_ll_valid,                 // load-linked executed
    input wire logic [35:0] i_ll_frame,          // its physical frame number
    input wire logic i_eret,                     // exception return executed
    input wire logic i_tlb_exc,                  // any TLB exception
    input wire logic [63:0] i_tlb_badvaddr,      // failing virtual address
    output logic o_relax_wait_cache,             // lift wait-cache limit
    output logic o_relax_wait_issue,             // lift wait-issue limit
    output logic o_relax_store_issue,            // lift store-issue limit
    output logic o_relax_store_fetch,            // lift store-fetch limit
    output logic o_instr_tlb_flush,              // instruction TLB flush pulse
    output logic o_branch_target_flush,          // branch target flush pulse
    output logic o_ras_disable,                  // return stack disabled
    output logic [31:0] o_feature_word           // feature word for the core
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    initial begin
        if ((CFG_VALUE & CMR_CFG_RSVD_MASK) != 32'h0) begin
            $error("cmr_regs: feature word sets reserved bits");
        end
    end

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [31:0] cfg_r;               // feature word
    logic [35:0] ll_frame;            // linked-load frame number
    logic [36:0] xc_cap;              // region and page pair, captured
    logic [36:0] xc_cap_nxt;          // value captured on a TLB exception
    logic [22:0] pte_base_r;          // page table base
    logic [3:0] relax_r;              // relax bits 7:4
    logic ras_off_r;                  // return-stack disable
    logic instr_tlb_flush_flush_r;               // flush pulse
    logic btb_flush_r;                // flush pulse
    logic hit_cfg;                    // address decodes
    logic hit_ll;
    logic hit_xc;
    logic hit_dg;
    logic wr_xc;                      // write strobes per register
    logic wr_dg;
    logic [63:0] ll_word;             // read views
    logic [63:0] xc_word;
    logic [63:0] dg_word;
    logic [63:0] rd_mux;

    // ****************************************************************
    // address decode
    // ****************************************************************
    assign hit_cfg = (i_cop_regnum == CMR_REG_CFG) && (i_cop_sel == CMR_SEL_CFG);
    assign hit_ll = (i_cop_regnum == CMR_REG_LL) && (i_cop_sel == CMR_SEL_LL);
    assign hit_xc = (i_cop_regnum == CMR_REG_XCTX) && (i_cop_sel == CMR_SEL_XCTX);
    assign hit_dg = (i_cop_regnum == CMR_REG_DIAG) && (i_cop_sel == CMR_SEL_DIAG);
    assign wr_xc = i_cop_wr && hit_xc;
    assign wr_dg = i_cop_wr && hit_dg;

    // ****************************************************************
    // feature presence word
    // ****************************************************************
    // reset loads the package reset value, then the masked build value every cycle; software never writes it
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            cfg_r <= CMR_CFG_RESET;
        end else begin
            cfg_r <= CFG_VALUE & ~CMR_CFG_RSVD_MASK;
        end
    end

    assign o_feature_word = cfg_r;

    // ****************************************************************
    // linked-load frame
    // ****************************************************************
    // a load-linked in the return cycle wins, so its reservation survives
    cmr_capture_reg #(
        .W(CMR_LL_W),
        .RST(CMR_LL_RESET)
    ) u_ll_frame (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_set(i_ll_valid),
        .i_set_val(i_ll_frame),
        .i_clr(i_eret),
        .o_val(ll_frame)
    );

    assign ll_word = {16'h0000, ll_frame, 12'h000};

    // ****************************************************************
    // extended page context
    // ****************************************************************
    // region above page pair, as laid out in the register
    assign xc_cap_nxt = {i_tlb_badvaddr[CMR_VA_REG_LSB +: CMR_XC_REG_W],
        i_tlb_badvaddr[CMR_VA_VPN_LSB +: CMR_XC_VPN_W]};

    // captured fields ignore software writes; no clear source
    cmr_capture_reg #(
        .W(CMR_XC_REG_W + CMR_XC_VPN_W),
        .RST(CMR_XC_CAP_RESET)
    ) u_xc_cap (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_set(i_tlb_exc),
        .i_set_val(xc_cap_nxt),
        .i_clr(1'b0),
        .o_val(xc_cap)
    );

    // base is written only by software
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            pte_base_r <= CMR_XC_PTE_RESET;
        end else if (wr_xc) begin
            pte_base_r <= i_cop_wdata[CMR_XC_PTE_LSB +: CMR_XC_PTE_W];
        end
    end

    // low four bits zero: page pair of 8-byte entries is 16 bytes apart
    assign xc_word = {pte_base_r, xc_cap, 4'h0};

    // ****************************************************************
    // diagnostic control
    // ****************************************************************
    // relax and return-stack bits are plain software state
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            relax_r <= CMR_DG_RESET[4:1];
            ras_off_r <= CMR_DG_RESET[0];
        end else if (wr_dg) begin
            relax_r <= i_cop_wdata[CMR_DG_WCAC_BIT:CMR_DG_SFET_BIT];
            ras_off_r <= i_cop_wdata[CMR_DG_RAS_BIT];
        end
    end

    // flush bits are commands: one pulse per write of one, read as zero
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            instr_tlb_flush_flush_r <= 1'b0;
            btb_flush_r <= 1'b0;
        end else begin
            instr_tlb_flush_flush_r <= wr_dg && i_cop_wdata[CMR_DG_INSTR_TLB_FLUSH_BIT];
            btb_flush_r <= wr_dg && i_cop_wdata[CMR_DG_BTB_BIT];
        end
    end

    assign dg_word = {56'h0, relax_r, 4'h0} | {63'h0, ras_off_r};

    assign o_relax_wait_cache = relax_r[3];
    assign o_relax_wait_issue = relax_r[2];
    assign o_relax_store_issue = relax_r[1];
    assign o_relax_store_fetch = relax_r[0];
    assign o_ras_disable = ras_off_r;
    assign o_instr_tlb_flush = instr_tlb_flush_flush_r;
    assign o_branch_target_flush = btb_flush_r;

    // ****************************************************************
    // read path
    // ****************************************************************
    // unmapped addresses read zero and drop the hit flag
    always_comb begin
        rd_mux = 64'h0;
        if (hit_cfg) begin
            rd_mux = {32'h0, cfg_r};
        end else if (hit_ll) begin
            rd_mux = ll_word;
        end else if (hit_xc) begin
            rd_mux = xc_word;
        end else if (hit_dg) begin
            rd_mux = dg_word;
        end
    end

    // registered answer, one cycle after the strobe, held until next read
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_cop_rdata <= 64'h0;
            o_cop_rhit <= 1'b0;
        end else if (i_cop_rd) begin
            o_cop_rdata <= rd_mux;
            o_cop_rhit <= hit_cfg || hit_ll || hit_xc || hit_dg;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_cop_rvalid <= 1'b0;
        end else begin
            o_cop_rvalid <= i_cop_rd;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_dg_write(int b);
        wr_dg && i_cop_wdata[b];
    endsequence

    sequence s_one_pulse_instr_tlb_flush;
        o_instr_tlb_flush ##1 !o_instr_tlb_flush;
    endsequence

    sequence s_one_pulse_btb;
        o_branch_target_flush ##1 !o_branch_target_flush;
    endsequence

    AST_CFG_CONST: assert property (!$past(i_resetn)
        || cfg_r == (CFG_VALUE & ~CMR_CFG_RSVD_MASK))
        else $error("feature word not at reset value");

    AST_CFG_RSVD: assert property ((cfg_r & CMR_CFG_RSVD_MASK) == 32'h0)
        else $error("feature word reserved bit set");

    AST_LL_RD: assert property (i_cop_rd && hit_ll && !i_ll_valid && !i_eret
        |=> o_cop_rdata == {16'h0000, $past(ll_frame), 12'h000} && o_cop_rhit)
        else $error("linked-load read layout wrong");

    AST_LL_ERET: assert property (i_eret && !i_ll_valid |=> ll_word == 64'h0)
        else $error("exception return did not clear linked-load");

    AST_XC_VPN: assert property (i_tlb_exc
        |=> xc_word[38:4] == $past(i_tlb_badvaddr[47:13]))
        else $error("page pair not captured");

    AST_XC_REG: assert property (i_tlb_exc
        |=> xc_word[40:39] == $past(i_tlb_badvaddr[63:62]) && xc_word[3:0] == 4'h0)
        else $error("region not captured");

    AST_PTE_HOLD: assert property (!wr_xc && i_tlb_exc |=> $stable(pte_base_r))
        else $error("hardware changed page table base");

    AST_RELAX: assert property (wr_dg |=> dg_word[7:4] == $past(i_cop_wdata[7:4])
        && dg_word[63:8] == 56'h0)
        else $error("relax bits not taken");

    AST_INSTR_TLB_FLUSH: assert property (s_dg_write(CMR_DG_INSTR_TLB_FLUSH_BIT) ##1 !wr_dg
        |-> s_one_pulse_instr_tlb_flush)
        else $error("instruction TLB flush not one pulse");

    AST_BTB: assert property (s_dg_write(CMR_DG_BTB_BIT) ##1 !wr_dg
        |-> s_one_pulse_btb)
        else $error("branch target flush not one pulse");

    AST_RAS: assert property (s_dg_write(CMR_DG_RAS_BIT) ##1 !wr_dg[*2]
        |-> o_ras_disable[*2])
        else $error("return stack not held disabled");

    // unmapped read: answer still comes, but empty and without the hit flag
    sequence s_unmapped_answer;
        o_cop_rvalid && !o_cop_rhit && o_cop_rdata == 64'h0;
    endsequence

    AST_RD_UNMAPPED: assert property (i_cop_rd && !(hit_cfg || hit_ll || hit_xc || hit_dg)
        |=> s_unmapped_answer)
        else $error("unmapped read not zero");

    // a load-linked always lands, even against a return in the same cycle
    AST_LL_CAP: assert property (i_ll_valid
        |=> ll_word[47:12] == $past(i_ll_frame))
        else $error("linked-load frame not captured");

    AST_PTE_WR: assert property (wr_xc
        |=> xc_word[63:41] == $past(i_cop_wdata[63:41]))
        else $error("page table base write lost");

    // command bits are strobes only, never stored state
    AST_DG_CMD_ZERO: assert property (i_cop_rd && hit_dg
        |=> o_cop_rdata[3:1] == 3'h0)
        else $error("diagnostic command bits read back");

    // feature word sits in the low half, upper half zero
    AST_CFG_RD: assert property (i_cop_rd && hit_cfg
        |=> o_cop_rdata == {32'h0, CFG_VALUE & ~CMR_CFG_RSVD_MASK} && o_cop_rhit)
        else $error("feature word read wrong");

endmodule

/* File: logic/cmr_pkg.sv */
// constants for the core miscellaneous control register group
// assumes a 64-bit coprocessor move path addressed by register and select number
package cmr_pkg;

    // ****************************************************************
    // register addresses (register number, select number)
    // ****************************************************************
    localparam logic [4:0] CMR_REG_CFG = 5'h10; // feature presence word
    localparam logic [2:0] CMR_SEL_CFG = 3'h3;
    localparam logic [4:0] CMR_REG_LL = 5'h11; // linked-load frame
    localparam logic [2:0] CMR_SEL_LL = 3'h0;
    localparam logic [4:0] CMR_REG_XCTX = 5'h14; // extended page context
    localparam logic [2:0] CMR_SEL_XCTX = 3'h0;
    localparam logic [4:0] CMR_REG_DIAG = 5'h16; // diagnostic control
    localparam logic [2:0] CMR_SEL_DIAG = 3'h0;

    // ****************************************************************
    // feature presence word
    // ****************************************************************
    localparam logic [31:0] CMR_CFG_RESET = 32'h000000A0;
    localparam logic [31:0] CMR_CFG_RSVD_MASK = 32'h7FFFFB08; // bits 30:11, 9:8, 3
    localparam int CMR_CFG_CONT_BIT = 31;
    localparam int CMR_CFG_DSP_BIT = 10;
    localparam int CMR_CFG_LPA_BIT = 7;
    localparam int CMR_CFG_EIC_BIT = 6;
    localparam int CMR_CFG_VINT_BIT = 5;
    localparam int CMR_CFG_SPAGE_BIT = 4;
    localparam int CMR_CFG_MT_BIT = 2;
    localparam int CMR_CFG_SMART_BIT = 1;
    localparam int CMR_CFG_TRACE_BIT = 0;

    // ****************************************************************
    // linked-load frame layout
    // ****************************************************************
    localparam int CMR_LL_LSB = 12;
    localparam int CMR_LL_W = 36;
    localparam logic [35:0] CMR_LL_RESET = 36'h0;

    // ****************************************************************
    // extended page context layout
    // ****************************************************************
    localparam int CMR_XC_VPN_LSB = 4;
    localparam int CMR_XC_VPN_W = 35;
    localparam int CMR_VA_VPN_LSB = 13;
    localparam int CMR_XC_REG_LSB = 39;
    localparam int CMR_XC_REG_W = 2;
    localparam int CMR_VA_REG_LSB = 62;
    localparam int CMR_XC_PTE_LSB = 41;
    localparam int CMR_XC_PTE_W = 23;
    localparam logic [22:0] CMR_XC_PTE_RESET = 23'h0;
    localparam logic [36:0] CMR_XC_CAP_RESET = 37'h0;

    // ****************************************************************
    // diagnostic control layout
    // ****************************************************************
    localparam int CMR_DG_RAS_BIT = 0;
    localparam int CMR_DG_BTB_BIT = 1;
    localparam int CMR_DG_INSTR_TLB_FLUSH_BIT = 2;
    localparam int CMR_DG_SFET_BIT = 4;
    localparam int CMR_DG_SISS_BIT = 5;
    localparam int CMR_DG_WISS_BIT = 6;
    localparam int CMR_DG_WCAC_BIT = 7;
    localparam logic [4:0] CMR_DG_RESET = 5'h00; // relax 7:4 and return-stack bit

endpackage

/* File: logic/cmr_capture_reg.sv */
// one hardware-captured field with a hardware clear
// assumes capture and clear are single-cycle strobes in the core clock domain
module cmr_capture_reg #(
    parameter int W = 36,                   // field width
    parameter logic [W-1:0] RST = '0        // value after reset
) (
    input wire logic i_ref_clk,             // core clock
    input wire logic i_resetn,              // synchronous reset, low
    input wire logic i_set,                 // capture strobe
    input wire logic [W-1:0] i_set_val,     // value to capture
    input wire logic i_clr,                 // clear strobe
    output logic [W-1:0] o_val              // held field
);

    // ****************************************************************
    // storage
    // ****************************************************************
    initial begin
        if (W < 1) begin
            $error("cmr_capture_reg: width must be at least one");
        end
    end

    // capture beats clear so an event in the clearing cycle is kept
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_val <= RST;
        end else if (i_set) begin
            o_val <= i_set_val;
        end else if (i_clr) begin
            o_val <= '0;
        end
    end

endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the core miscellaneous control register group
// assumes cmr_regs and cmr_pkg compiled first; the bench alone drives every input
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import cmr_pkg::*;

    // ****************************************************************
    // stimulus signals, all given a value at time zero
    // ****************************************************************
    logic i_ref_clk = 1'b0; // core clock
    logic i_resetn = 1'b0; // held low at start
    logic i_cop_rd = 1'b0;
    logic i_cop_wr = 1'b0;
    logic [4:0] i_cop_regnum = 5'h00;
    logic [2:0] i_cop_sel = 3'h0;
    logic [63:0] i_cop_wdata = 64'h0;
    logic i_ll_valid = 1'b0;
    logic [35:0] i_ll_frame = 36'h0;
    logic i_eret = 1'b0;
    logic i_tlb_exc = 1'b0;
    logic [63:0] i_tlb_badvaddr = 64'h0;
    logic [63:0] o_cop_rdata;
    logic o_cop_rvalid, o_cop_rhit;
    logic o_relax_wait_cache, o_relax_wait_issue, o_relax_store_issue, o_relax_store_fetch;
    logic o_instr_tlb_flush, o_branch_target_flush, o_ras_disable;
    logic [31:0] o_feature_word;
    int fail_count = 0; // mismatches
    int tests_run = 0; // comparisons
    logic [64:0] rd_q[$]; // expected {hit, data} per read
    logic [1:0] fl_q[$]; // expected {instr_tlb_flush, btb} per flush pulse
    logic [63:0] seed = 64'h4C; // xorshift state
    logic [63:0] r, va, p, w;
    logic [35:0] f;
    logic [64:0] e;
    logic [1:0] fl; // expected flush pair

    cmr_regs i_cmr_regs (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_cop_rd(i_cop_rd),
        .i_cop_wr(i_cop_wr), .i_cop_regnum(i_cop_regnum), .i_cop_sel(i_cop_sel),
        .i_cop_wdata(i_cop_wdata), .o_cop_rdata(o_cop_rdata), .o_cop_rvalid(o_cop_rvalid),
        .o_cop_rhit(o_cop_rhit), .i_ll_valid(i_ll_valid), .i_ll_frame(i_ll_frame),
        .i_eret(i_eret), .i_tlb_exc(i_tlb_exc), .i_tlb_badvaddr(i_tlb_badvaddr),
        .o_relax_wait_cache(o_relax_wait_cache), .o_relax_wait_issue(o_relax_wait_issue),
        .o_relax_store_issue(o_relax_store_issue), .o_relax_store_fetch(o_relax_store_fetch),
        .o_instr_tlb_flush(o_instr_tlb_flush), .o_branch_target_flush(o_branch_target_flush),
        .o_ras_disable(o_ras_disable), .o_feature_word(o_feature_word));

    // 40 ns period
    initial begin
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [63:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 7);
        seed = seed ^ (seed << 17);
        return seed;
    endfunction

    task automatic chk_read(input logic [64:0] exp, input logic [63:0] dat, input logic hit);
        tests_run++;
        if ({hit, dat} !== exp) begin
            fail_count++;
            $display("BAD read exp %h seen %h", exp, {hit, dat});
        end
    endtask

    task automatic chk_lvl(input string nm, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, exp, got);
        end
    endtask

    // one register access held for one cycle; caller chains them back to back
    task automatic cop(input logic rd, input logic wr, input logic [4:0] rn, input logic [2:0] sl,
        input logic [63:0] wd, input logic [64:0] exp);
        i_cop_rd = rd;
        i_cop_wr = wr;
        i_cop_regnum = rn;
        i_cop_sel = sl;
        i_cop_wdata = wd;
        if (rd) rd_q.push_back(exp);
        @(negedge i_ref_clk);
    endtask

    // pipeline event strobes, left up until idle so no signal is set twice per step
    task automatic ev(input logic ll, input logic [35:0] fr, input logic er, input logic tl,
        input logic [63:0] a);
        i_ll_valid = ll;
        i_ll_frame = fr;
        i_eret = er;
        i_tlb_exc = tl;
        i_tlb_badvaddr = a;
        @(negedge i_ref_clk);
    endtask

    task automatic idle();
        i_cop_rd = 1'b0;
        i_cop_wr = 1'b0;
        i_ll_valid = 1'b0;
        i_eret = 1'b0;
        i_tlb_exc = 1'b0;
        @(negedge i_ref_clk);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ****************************************************************
    // monitor: outputs are registered, so the falling edge sees them settled
    // ****************************************************************
    always @(negedge i_ref_clk) begin
        if (o_cop_rvalid === 1'b1) begin
            if (rd_q.size() == 0) chk_lvl("unexpected rvalid", 64'h0, 64'h1);
            else chk_read(rd_q.pop_front(), o_cop_rdata, o_cop_rhit);
        end
        if (o_instr_tlb_flush !== 1'b0 || o_branch_target_flush !== 1'b0) begin
            fl = (fl_q.size() == 0) ? 2'b00 : fl_q.pop_front();
            chk_lvl("flush", {62'h0, fl},
                {62'h0, o_instr_tlb_flush, o_branch_target_flush});
        end
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        fail_count++;
        final_report();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(negedge i_ref_clk);
        i_resetn = 1'b1;
        @(negedge i_ref_clk);
        // reset values, then an unmapped select
        cop(1, 0, CMR_REG_LL, CMR_SEL_LL, 64'h0, {1'b1, 64'h0});
        cop(1, 0, CMR_REG_XCTX, CMR_SEL_XCTX, 64'h0, {1'b1, 64'h0});
        cop(1, 0, CMR_REG_DIAG, CMR_SEL_DIAG, 64'h0, {1'b1, 64'h0});
        cop(1, 0, CMR_REG_CFG, CMR_SEL_CFG, 64'h0, {1'b1, 64'h00000000000000A0});
        cop(1, 0, 5'h10, 3'h0, 64'h0, {1'b0, 64'h0});
        r = rnd();
        // write to the feature word must not stick; read right behind it
        cop(0, 1, CMR_REG_CFG, CMR_SEL_CFG, {32'h0, r[31:0] & ~CMR_CFG_RSVD_MASK}, 65'h0);
        cop(1, 0, CMR_REG_CFG, CMR_SEL_CFG, 64'h0, {1'b1, 64'h00000000000000A0});
        idle();
        chk_lvl("feature_word", 64'h00000000000000A0, {32'h0, o_feature_word});
        // linked-load capture, refused write, clear on return, capture beats clear
        for (int k = 0; k < 3; k++) begin
            r = rnd();
            f = r[35:0];
            ev(1'b1, f, k == 2, 1'b0, 64'h0);
            cop(1, 0, CMR_REG_LL, CMR_SEL_LL, 64'h0, {1'b1, 16'h0, f, 12'h000});
            cop(0, 1, CMR_REG_LL, CMR_SEL_LL, {16'h0, ~f, 12'h000}, 65'h0);
            cop(1, 0, CMR_REG_LL, CMR_SEL_LL, 64'h0, {1'b1, 16'h0, f, 12'h000});
            idle();
            ev(1'b0, 36'h0, 1'b1, 1'b0, 64'h0);
            cop(1, 0, CMR_REG_LL, CMR_SEL_LL, 64'h0, {1'b1, 64'h0});
            idle();
        end
        // context: software base, then every region code captured on a fault
        p = rnd();
        cop(0, 1, CMR_REG_XCTX, CMR_SEL_XCTX, {p[22:0], 41'h0}, 65'h0);
        for (int k = 0; k < 4; k++) begin
            va = rnd();
            va[63:62] = k[1:0];
            ev(1'b0, 36'h0, 1'b0, 1'b1, va);
            e = {1'b1, p[22:0], va[63:62], va[47:13], 4'h0};
            cop(1, 0, CMR_REG_XCTX, CMR_SEL_XCTX, 64'h0, e);
            idle();
        end
        // base write in the same cycle as a fault: each side keeps its own field
        va = rnd();
        p = rnd();
        ev(1'b0, 36'h0, 1'b0, 1'b1, va);
        cop(0, 1, CMR_REG_XCTX, CMR_SEL_XCTX, {p[22:0], 41'h0}, 65'h0);
        idle();
        e = {1'b1, p[22:0], va[63:62], va[47:13], 4'h0};
        cop(1, 0, CMR_REG_XCTX, CMR_SEL_XCTX, 64'h0, e);
        idle();
        // diagnostic: relax levels, one-cycle flush pulses, command bits read zero
        for (int k = 0; k < 5; k++) begin
            r = rnd();
            w = (k == 0) ? 64'hF5 : (k == 1) ? 64'h02 : (k == 2) ? 64'h06 : (r & 64'hF7);
            if (w[2:1] != 2'b00) fl_q.push_back(w[2:1]);
            cop(0, 1, CMR_REG_DIAG, CMR_SEL_DIAG, w, 65'h0);
            idle();
            chk_lvl("relax_ras", {59'h0, w[7:4], w[0]},
                {59'h0, o_relax_wait_cache, o_relax_wait_issue, o_relax_store_issue,
                o_relax_store_fetch, o_ras_disable});
            cop(1, 0, CMR_REG_DIAG, CMR_SEL_DIAG, 64'h0,
                {1'b1, 56'h0, w[7:4], 3'h0, w[0]});
            idle();
        end
        // mid-run reset: software and captured state both return to zero
        i_resetn = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        i_resetn = 1'b1;
        @(negedge i_ref_clk);
        chk_lvl("relax_ras_rst", 64'h0,
            {59'h0, o_relax_wait_cache, o_relax_wait_issue, o_relax_store_issue,
            o_relax_store_fetch, o_ras_disable});
        cop(1, 0, CMR_REG_XCTX, CMR_SEL_XCTX, 64'h0, {1'b1, 64'h0});
        cop(1, 0, CMR_REG_DIAG, CMR_SEL_DIAG, 64'h0, {1'b1, 64'h0});
        cop(1, 0, CMR_REG_CFG, CMR_SEL_CFG, 64'h0, {1'b1, 64'h00000000000000A0});
        idle();
        repeat (2) @(negedge i_ref_clk);
        // every noted result must have shown up
        chk_lvl("pending", 64'h0, {32'h0, rd_q.size() + fl_q.size()});
        final_report();
    end
endmodule
